/* common/dmt_pkg.sv */
// constants shared by the dual mode timer design
package dmt_pkg;
   // register offsets
   localparam logic [7:0] ADDR_B_CTRL   = 8'hea;
   localparam logic [7:0] ADDR_MAIN_CTL = 8'heb;
   localparam logic [7:0] ADDR_INT_EN   = 8'hed;
   localparam logic [7:0] ADDR_INT_PEND = 8'hee;
   localparam logic [7:0] ADDR_LOW_CNT  = 8'he4;
   localparam logic [7:0] ADDR_HIGH_CNT = 8'he5;
   localparam logic [7:0] ADDR_LOW_REF  = 8'he6;
   localparam logic [7:0] ADDR_HIGH_REF = 8'he7;

   // control fields; run, clear and clock select shared by both control registers, wide and mode main only
   localparam int CTL_WIDE = 0;
   localparam int CTL_RUN  = 1;
   localparam int CTL_CLR  = 2;
   localparam int MODE_LSB = 3;
   localparam int CLK_LSB  = 5;
   localparam logic [7:0] MAIN_STORE = 8'hfb;
   localparam logic [7:0] B_STORE    = 8'he2;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   localparam logic [1:0] MODE_INTERVAL = 2'h0;
   localparam logic [1:0] MODE_CAP_RISE = 2'h1;
   localparam logic [1:0] MODE_CAP_FALL = 2'h2;
   localparam logic [1:0] MODE_PWM      = 2'h3;

   localparam logic [2:0] CLK_DIV1024  = 3'h0;
   localparam logic [2:0] CLK_DIV256   = 3'h1;
   localparam logic [2:0] CLK_DIV64    = 3'h2;
   localparam logic [2:0] CLK_DIV8     = 3'h3;
   localparam logic [2:0] CLK_DIV1     = 3'h4;
   localparam logic [2:0] CLK_EXT_RISE = 3'h5;

   localparam int         DIV_W     = 10;
   localparam logic [9:0] MASK_1024 = 10'h3ff;
   localparam logic [9:0] MASK_256  = 10'h0ff;
   localparam logic [9:0] MASK_64   = 10'h03f;
   localparam logic [9:0] MASK_8    = 10'h007;
   localparam logic [9:0] MASK_1    = 10'h000;

   // interrupt enable and pending bits
   localparam int         PND_OVF   = 2;
   localparam int         PND_MATCH = 3;
   localparam int         PND_B     = 4;
   localparam logic [7:0] INT_BITS  = 8'h1c;
   localparam logic [7:0] INT_RESET = 8'h00;

   localparam logic [1:0]  CAP_SRC_PIN = 2'h0;
   localparam logic [15:0] TOP_WIDE    = 16'hffff;
   localparam logic [15:0] TOP_SPLIT   = 16'h00ff;
endpackage : dmt_pkg

/* common/dmt_tick_if.sv */
// prescaler select and tick between timer and prescaler
`timescale 1ns/1ps
`default_nettype none
interface dmt_tick_if;
   logic [2:0] clk_sel;
   logic       run;
   logic       tick;
   modport prescaler (input clk_sel, input run, output tick);
   modport timer (output clk_sel, output run, input tick);
endinterface : dmt_tick_if
`default_nettype wire

/* verilog/dmt_prescaler.sv */
// system clock divider with selectable ratio
`timescale 1ns/1ps
`default_nettype none
module dmt_prescaler #(
   parameter int DIV_W = dmt_pkg::DIV_W
) (
   input wire logic          clk,
   input wire logic          rst,
   dmt_tick_if.prescaler     tk
);
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] mask;
   logic             internal;

   always_comb begin
      internal = 1'b1;
      case (tk.clk_sel)
         dmt_pkg::CLK_DIV1024: mask = DIV_W'(dmt_pkg::MASK_1024);
         dmt_pkg::CLK_DIV256:  mask = DIV_W'(dmt_pkg::MASK_256);
         dmt_pkg::CLK_DIV64:   mask = DIV_W'(dmt_pkg::MASK_64);
         dmt_pkg::CLK_DIV8:    mask = DIV_W'(dmt_pkg::MASK_8);
         dmt_pkg::CLK_DIV1:    mask = DIV_W'(dmt_pkg::MASK_1);
         default: begin
            mask     = DIV_W'(dmt_pkg::MASK_1024);
            internal = 1'b0;
         end
      endcase
   end

   // restarts from zero whenever the timer stops
   always_ff @(posedge clk) begin
      if (rst || !tk.run)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end

   assign tk.tick = tk.run && internal && ((div_q & mask) == mask);
endmodule : dmt_prescaler
`default_nettype wire

/* verilog/dmt_pin_sync.sv */
// two-stage pin synchroniser with edge pulses
`timescale 1ns/1ps
`default_nettype none
module dmt_pin_sync #(
   parameter int N = 2
) (
   input wire logic         clk,
   input wire logic         rst,
   input wire logic [N-1:0] pin,
   output logic     [N-1:0] rise,
   output logic     [N-1:0] fall
);
   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;
   logic [N-1:0] prev_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule : dmt_pin_sync
`default_nettype wire

/* verilog/dmt_timer.sv */
// dual mode timer: one 16-bit timer or two 8-bit timers
//
// How it works
// - main control bit 0 high gives one 16-bit timer, low gives timers A and B.
// - counter clock is system clock over 1024/256/64/8/1, or external pin edges.
// - reset clears main control: interval mode, divide by 1024, stopped.
// - writing 1 to main control clear bit zeroes the timer counter.
// - overflow pending clears on service acknowledge or software writing 0.
// - match request needs run bit and enable bit 3; pending bit 3 readable.
// - interval mode: counter equal to reference raises match and restarts counter.
// - interval mode: every match inverts the toggle pin.
// - PWM mode: match leaves counter running; 16-bit counter wraps to zero.
// - PWM pin low while reference at or below counter, high when above.
// - capture mode: selected pin edge copies counter into reference register.
// - capture mode: overflow raises overflow event, each capture raises match event.
// - split mode timer A gives all three modes on 8 bits.
// - split mode timer B: interval only, own prescaler, own match interrupt.
// - reset clears timer B control; its clear bit zeroes timer B counter.
// - 8-bit PWM counter wraps from FF to zero, period 256 clocks.
`timescale 1ns/1ps
`default_nettype none
module dmt_timer (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   output logic     [7:0]  reg_rdata,
   input wire logic        capture_input_pin,
   input wire logic        external_clock_pin,
   input wire logic [1:0]  capture_src_sel,
   input wire logic        ovf_service_ack,
   output logic            match_toggle_pin,
   output logic            pwm_output_pin,
   output logic            overflow_interrupt,
   output logic            match_capture_interrupt,
   output logic            timer_b_interrupt
);
   logic [7:0]  main_ctl_q;
   logic [7:0]  b_ctl_q;
   logic [7:0]  int_en_q;
   logic [7:0]  pend_q;
   logic [7:0]  pend_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] ref_q;
   logic [15:0] a_cnt;
   logic [15:0] a_ref;
   logic [15:0] a_top;
   logic [15:0] a_inc;
   logic [1:0]  rise;
   logic [1:0]  fall;
   logic        wide;
   logic        run_a;
   logic        run_b;
   logic [1:0]  mode;
   logic [2:0]  a_sel;
   logic        wr_main;
   logic        wr_b;
   logic        wr_pend;
   logic        clr_a;
   logic        clr_b;
   logic        ext_tick;
   logic        tick_a;
   logic        tick_b;
   logic        a_match;
   logic        a_last;
   logic        b_match;
   logic        cap_edge;
   logic        ev_match;
   logic        ev_ovf;
   logic        ev_b;

   function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] off);
      return we && (a == off);
   endfunction : wr_hit

   dmt_tick_if ta ();
   dmt_tick_if tb ();

   dmt_prescaler u_pre_a (.clk(clk), .rst(rst), .tk(ta.prescaler));
   dmt_prescaler u_pre_b (.clk(clk), .rst(rst), .tk(tb.prescaler));

   // bit 0 capture pin, bit 1 external clock pin
   dmt_pin_sync #(.N(2)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .pin  ({external_clock_pin, capture_input_pin}),
      .rise (rise),
      .fall (fall)
   );

   assign wide    = main_ctl_q[dmt_pkg::CTL_WIDE];
   assign run_a   = main_ctl_q[dmt_pkg::CTL_RUN];
   assign run_b   = b_ctl_q[dmt_pkg::CTL_RUN] && !wide;
   assign mode    = main_ctl_q[dmt_pkg::MODE_LSB +: 2];
   assign a_sel   = main_ctl_q[dmt_pkg::CLK_LSB +: 3];
   assign wr_main = wr_hit(reg_wr, reg_addr, dmt_pkg::ADDR_MAIN_CTL);
   assign wr_b    = wr_hit(reg_wr, reg_addr, dmt_pkg::ADDR_B_CTRL);
   assign wr_pend = wr_hit(reg_wr, reg_addr, dmt_pkg::ADDR_INT_PEND);
   assign clr_a   = wr_main && reg_wdata[dmt_pkg::CTL_CLR];
   assign clr_b   = wr_b && reg_wdata[dmt_pkg::CTL_CLR] && !wide;

   assign ta.clk_sel = a_sel;
   assign ta.run     = run_a;
   assign tb.clk_sel = b_ctl_q[dmt_pkg::CLK_LSB +: 3];
   assign tb.run     = run_b;

   // codes above the internal ratios count external pin edges
   assign ext_tick = (a_sel == dmt_pkg::CLK_EXT_RISE) ? rise[1] :
                     (a_sel > dmt_pkg::CLK_EXT_RISE) ? fall[1] : 1'b0;
   assign tick_a   = ta.tick || (run_a && ext_tick);
   assign tick_b   = tb.tick;

   // timer A views only the low byte in split mode
   assign a_cnt   = wide ? cnt_q : {8'h00, cnt_q[7:0]};
   assign a_ref   = wide ? ref_q : {8'h00, ref_q[7:0]};
   assign a_top   = wide ? dmt_pkg::TOP_WIDE : dmt_pkg::TOP_SPLIT;
   assign a_match = (a_cnt == a_ref);
   assign a_last  = (a_cnt == a_top);
   assign b_match = (cnt_q[15:8] == ref_q[15:8]);

   assign cap_edge = run_a && (capture_src_sel == dmt_pkg::CAP_SRC_PIN) &&
                     (((mode == dmt_pkg::MODE_CAP_RISE) && rise[0]) ||
                      ((mode == dmt_pkg::MODE_CAP_FALL) && fall[0]));

   assign ev_match = tick_a && a_match &&
                     ((mode == dmt_pkg::MODE_INTERVAL) || (mode == dmt_pkg::MODE_PWM));
   assign ev_ovf   = tick_a && a_last && !((mode == dmt_pkg::MODE_INTERVAL) && a_match);
   assign ev_b     = tick_b && b_match;

   // interval restarts on match, other modes wrap at the top
   always_comb begin
      if (mode == dmt_pkg::MODE_INTERVAL)
         a_inc = a_match ? '0 : a_cnt + 16'h0001;
      else
         a_inc = a_last ? '0 : a_cnt + 16'h0001;
   end

   always_comb begin
      cnt_d = cnt_q;
      if (tick_a)
         cnt_d = wide ? a_inc : {cnt_q[15:8], a_inc[7:0]};
      if (tick_b)
         cnt_d[15:8] = b_match ? 8'h00 : cnt_q[15:8] + 8'h01;
      if (clr_a) begin
         if (wide)
            cnt_d = '0;
         else
            cnt_d[7:0] = 8'h00;
      end
      if (clr_b)
         cnt_d[15:8] = 8'h00;
   end

   always_ff @(posedge clk) begin
      if (rst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   // control registers; clear bit acts on write and is not stored
   always_ff @(posedge clk) begin
      if (rst) begin
         main_ctl_q <= dmt_pkg::CTRL_RESET;
         b_ctl_q    <= dmt_pkg::CTRL_RESET;
         int_en_q   <= dmt_pkg::INT_RESET;
      end else begin
         if (wr_main)
            main_ctl_q <= reg_wdata & dmt_pkg::MAIN_STORE;
         if (wr_b)
            b_ctl_q <= reg_wdata & dmt_pkg::B_STORE;
         if (wr_hit(reg_wr, reg_addr, dmt_pkg::ADDR_INT_EN))
            int_en_q <= reg_wdata & dmt_pkg::INT_BITS;
      end
   end

   // reference registers; a capture wins over a software write
   always_ff @(posedge clk) begin
      if (rst)
         ref_q <= '0;
      else if (cap_edge && wide)
         ref_q <= cnt_q;
      else begin
         if (cap_edge)
            ref_q[7:0] <= cnt_q[7:0];
         else if (wr_hit(reg_wr, reg_addr, dmt_pkg::ADDR_LOW_REF))
            ref_q[7:0] <= reg_wdata;
         if (wr_hit(reg_wr, reg_addr, dmt_pkg::ADDR_HIGH_REF))
            ref_q[15:8] <= reg_wdata;
      end
   end

   // pending flags: set wins over any clear in the same cycle
   always_comb begin
      pend_d = pend_q;
      if (wr_pend)
         pend_d = pend_q & (reg_wdata | ~dmt_pkg::INT_BITS);
      if (ovf_service_ack)
         pend_d[dmt_pkg::PND_OVF] = 1'b0;
      if (ev_ovf)
         pend_d[dmt_pkg::PND_OVF] = 1'b1;
      if (ev_match || cap_edge)
         pend_d[dmt_pkg::PND_MATCH] = 1'b1;
      if (ev_b)
         pend_d[dmt_pkg::PND_B] = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (rst)
         pend_q <= dmt_pkg::INT_RESET;
      else
         pend_q <= pend_d;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         overflow_interrupt      <= 1'b0;
         match_capture_interrupt <= 1'b0;
         timer_b_interrupt       <= 1'b0;
      end else begin
         overflow_interrupt      <= pend_q[dmt_pkg::PND_OVF] && int_en_q[dmt_pkg::PND_OVF];
         match_capture_interrupt <= pend_q[dmt_pkg::PND_MATCH] && run_a &&
                                    int_en_q[dmt_pkg::PND_MATCH];
         timer_b_interrupt       <= pend_q[dmt_pkg::PND_B] && run_b &&
                                    int_en_q[dmt_pkg::PND_B];
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         match_toggle_pin <= 1'b0;
      else if (ev_match && (mode == dmt_pkg::MODE_INTERVAL))
         match_toggle_pin <= !match_toggle_pin;
   end

   always_ff @(posedge clk) begin
      if (rst)
         pwm_output_pin <= 1'b0;
      else
         pwm_output_pin <= (mode == dmt_pkg::MODE_PWM) && (a_ref > a_cnt);
   end

   always_ff @(posedge clk) begin
      if (rst)
         reg_rdata <= 8'h00;
      else begin
         case (reg_addr)
            dmt_pkg::ADDR_MAIN_CTL: reg_rdata <= main_ctl_q;
            dmt_pkg::ADDR_B_CTRL:   reg_rdata <= b_ctl_q;
            dmt_pkg::ADDR_INT_EN:   reg_rdata <= int_en_q;
            dmt_pkg::ADDR_INT_PEND: reg_rdata <= pend_q;
            dmt_pkg::ADDR_LOW_CNT:  reg_rdata <= cnt_q[7:0];
            dmt_pkg::ADDR_HIGH_CNT: reg_rdata <= cnt_q[15:8];
            dmt_pkg::ADDR_LOW_REF:  reg_rdata <= ref_q[7:0];
            dmt_pkg::ADDR_HIGH_REF: reg_rdata <= ref_q[15:8];
            default:                reg_rdata <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   reset_ctrl_a: assert property (disable iff (1'b0) rst |=> main_ctl_q == 8'h00)
      else $error("main control not cleared by reset");
   reset_b_ctrl_a: assert property (disable iff (1'b0) rst |=> b_ctl_q == 8'h00)
      else $error("timer b control not cleared by reset");
   clear_cnt_a: assert property (clr_a && wide |=> cnt_q == 16'h0000)
      else $error("counter not cleared by clear bit");
   interval_wrap_a: assert property (
      ev_match && mode == dmt_pkg::MODE_INTERVAL && !clr_a
      |=> a_cnt == 16'h0000 && match_toggle_pin != $past(match_toggle_pin))
      else $error("interval match did not restart and toggle");
   pwm_wrap_a: assert property (
      tick_a && mode == dmt_pkg::MODE_PWM && a_last && !clr_a
      |=> a_cnt == 16'h0000 && pend_q[dmt_pkg::PND_OVF])
      else $error("pwm counter did not wrap with overflow");
   pwm_hold_a: assert property (
      tick_a && mode == dmt_pkg::MODE_PWM && a_match && !a_last && !clr_a && !wr_main
      |=> a_cnt == $past(a_cnt) + 16'h0001)
      else $error("pwm match cleared the counter");
   pwm_level_a: assert property (
      mode == dmt_pkg::MODE_PWM && $stable(mode)
      |=> pwm_output_pin == ($past(a_ref) > $past(a_cnt)))
      else $error("pwm pin level wrong");
   capture_load_a: assert property (
      cap_edge && wide
      |=> ref_q == $past(cnt_q) && pend_q[dmt_pkg::PND_MATCH])
      else $error("capture did not load reference");
   match_gate_a: assert property (
      match_capture_interrupt
      |-> $past(pend_q[dmt_pkg::PND_MATCH] && run_a && int_en_q[dmt_pkg::PND_MATCH]))
      else $error("match request without enables");
   match_keep_a: assert property (
      pend_q[dmt_pkg::PND_MATCH] && !wr_pend |=> pend_q[dmt_pkg::PND_MATCH])
      else $error("match pending cleared without a write");
   ovf_ack_a: assert property (ovf_service_ack && !ev_ovf |=> !pend_q[dmt_pkg::PND_OVF])
      else $error("overflow pending not cleared on service");
   b_match_a: assert property (
      ev_b && !clr_b |=> cnt_q[15:8] == 8'h00 && pend_q[dmt_pkg::PND_B])
      else $error("timer b match lost");

   interval_cov: cover property (ev_match && mode == dmt_pkg::MODE_INTERVAL);
   capture_cov: cover property (cap_edge);
   pwm_cov: cover property (mode == dmt_pkg::MODE_PWM && pwm_output_pin ##1 !pwm_output_pin);
   b_cov: cover property (ev_b);
endmodule : dmt_timer
`default_nettype wire

/* verif/dmt_pin_model.sv */
// pin side model: capture input and external counting clock
`timescale 1ns/1ps
`default_nettype none
module dmt_pin_model (
   input wire logic clk,
   output logic     cap,
   output logic     ext
);
   initial begin
      cap = 1'b0;
      ext = 1'b0;
   end

   // level held until the next call, a pin has no release
   task automatic set_cap(input logic lvl);
      @(posedge clk);
      #1;
      cap = lvl;
   endtask : set_cap

   // each level held three clocks so the synchroniser sees it
   task automatic pulse_ext(input int n);
      repeat (n) begin
         repeat (3) @(posedge clk);
         #1;
         ext = 1'b1;
         repeat (3) @(posedge clk);
         #1;
         ext = 1'b0;
      end
   endtask : pulse_ext
endmodule : dmt_pin_model
`default_nettype wire

/* verif/dual_mode_timer_sixteen_or_two_eight_bench.sv */
// self-checking bench for the dual mode timer
`timescale 1ns/1ps
`default_nettype none
module dual_mode_timer_sixteen_or_two_eight_bench;
   logic       clk, rst, reg_wr, ack;
   logic [7:0] addr, wdata, rdata, r, v;
   logic [1:0] src;
   wire logic  cap, ext, tog, pwm, ovf_irq, mc_irq, b_irq;
   int         n_mismatch, comparisons, seed, i, k;

   dmt_timer DUT (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(reg_wr),
      .reg_wdata(wdata), .reg_rdata(rdata), .capture_input_pin(cap),
      .external_clock_pin(ext), .capture_src_sel(src), .ovf_service_ack(ack),
      .match_toggle_pin(tog), .pwm_output_pin(pwm), .overflow_interrupt(ovf_irq),
      .match_capture_interrupt(mc_irq), .timer_b_interrupt(b_irq));
   dmt_pin_model PM (.clk(clk), .cap(cap), .ext(ext));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // system clocks per count for each internal clock code
   function automatic int ratio(input int sel);
      return (sel == 0) ? 1024 : (sel == 1) ? 256 : (sel == 2) ? 64 : (sel == 3) ? 8 : 1;
   endfunction : ratio

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      reg_wr = 1'b1;
      step(1);
      reg_wr = 1'b0;
      step(1);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      addr = a;
      step(1);
      v = rdata;
   endtask : rd

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic summarize;
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   initial begin
      #(20 * 40000);
      n_mismatch++;
      summarize();
   end

   initial begin
      seed = 32'h9495;
      n_mismatch = 0;
      comparisons = 0;
      rst = 1'b1;
      reg_wr = 1'b0;
      ack = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      src = 2'h0;
      step(2);
      rst = 1'b0;
      rd(dmt_pkg::ADDR_B_CTRL);
      check("b_ctrl_rst", v, 8'h00);
      rd(dmt_pkg::ADDR_MAIN_CTL);
      check("main_rst", v, 8'h00);
      rd(8'h10);
      check("unmapped", v, 8'h00);
      for (i = 0; i < 3; i++) begin
         r = 8'($random(seed));
         wr(dmt_pkg::ADDR_MAIN_CTL, r);
         rd(dmt_pkg::ADDR_MAIN_CTL);
         check("main_rw", v, r & dmt_pkg::MAIN_STORE);
         wr(dmt_pkg::ADDR_B_CTRL, r);
         rd(dmt_pkg::ADDR_B_CTRL);
         check("b_rw", v, r & dmt_pkg::B_STORE);
      end
      wr(dmt_pkg::ADDR_B_CTRL, 8'h00);
      // 16-bit interval at full rate
      r = 8'h08 + (8'($random(seed)) & 8'h1f);
      wr(dmt_pkg::ADDR_LOW_REF, r);
      wr(dmt_pkg::ADDR_HIGH_REF, 8'h00);
      wr(dmt_pkg::ADDR_INT_PEND, 8'h00);
      wr(dmt_pkg::ADDR_INT_EN, dmt_pkg::INT_BITS);
      // clear as well: the random phase may have left the counter past the reference
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h87);
      // the random phase may also have left the toggle pin high
      v[0] = tog;
      for (k = 0; k < 300 && tog === v[0]; k++) step(1);
      for (k = 0; k < 300 && tog !== v[0]; k++) step(1);
      check("interval", 16'(k), 16'(r) + 16'h1);
      check("match_irq", mc_irq, 1'b1);
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h81);
      check("match_irq_stop", mc_irq, 1'b0);
      rd(dmt_pkg::ADDR_INT_PEND);
      check("pend3_held", v[3], 1'b1);
      wr(dmt_pkg::ADDR_INT_PEND, 8'h00);
      rd(dmt_pkg::ADDR_INT_PEND);
      check("pend3_clr", v[3], 1'b0);
      // counter clear and prescaler ratios
      wr(dmt_pkg::ADDR_HIGH_REF, 8'hff);
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h83);
      step(100);
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h87);
      rd(dmt_pkg::ADDR_LOW_CNT);
      check("clear", v < 8'h05, 1'b1);
      for (i = 0; i < 4; i++) begin
         wr(dmt_pkg::ADDR_MAIN_CTL, 8'h00);
         wr(dmt_pkg::ADDR_MAIN_CTL, {3'(i), 5'h07});
         step(4 * ratio(i));
         rd(dmt_pkg::ADDR_LOW_CNT);
         check("prescale", v >= 8'h03 && v <= 8'h05, 1'b1);
      end
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'ha7);
      k = 3 + ($random(seed) & 7);
      PM.pulse_ext(k);
      step(4);
      rd(dmt_pkg::ADDR_LOW_CNT);
      check("ext_clock", v, 8'(k));
      // 8-bit pwm, free running
      r = 8'($random(seed));
      wr(dmt_pkg::ADDR_INT_PEND, 8'h00);
      wr(dmt_pkg::ADDR_LOW_REF, r);
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h9e);
      step(300);
      k = 0;
      for (i = 0; i < 256; i++) begin
         k += (pwm === 1'b1);
         step(1);
      end
      check("pwm_high", 16'(k), 16'(r));
      rd(dmt_pkg::ADDR_INT_PEND);
      check("pwm_wrap", v[2], 1'b1);
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h00);
      check("ovf_irq", ovf_irq, 1'b1);
      ack = 1'b1;
      step(1);
      ack = 1'b0;
      step(2);
      check("ovf_ack", ovf_irq, 1'b0);
      // capture: refused source, then falling edge
      src = 2'h1;
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h8a);
      // the pwm run left a match pending
      wr(dmt_pkg::ADDR_INT_PEND, 8'h00);
      PM.set_cap(1'b1);
      step(6);
      rd(dmt_pkg::ADDR_INT_PEND);
      check("cap_src_off", v[3], 1'b0);
      src = 2'h0;
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h97);
      k = 4 + ($random(seed) & 31);
      step(k);
      PM.set_cap(1'b0);
      step(8);
      rd(dmt_pkg::ADDR_LOW_REF);
      check("cap_value", v >= 8'(k + 2) && v <= 8'(k + 7), 1'b1);
      rd(dmt_pkg::ADDR_HIGH_REF);
      check("cap_high", v, 8'h00);
      rd(dmt_pkg::ADDR_INT_PEND);
      check("cap_pend", v[3], 1'b1);
      wr(dmt_pkg::ADDR_INT_PEND, 8'h00);
      // split capture so the 8-bit counter overflows quickly
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h96);
      step(300);
      rd(dmt_pkg::ADDR_INT_PEND);
      check("cap_ovf", v[2], 1'b1);
      // timer b in split mode
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h00);
      wr(dmt_pkg::ADDR_INT_PEND, 8'h00);
      wr(dmt_pkg::ADDR_HIGH_REF, 8'h10 + (8'($random(seed)) & 8'h0f));
      wr(dmt_pkg::ADDR_B_CTRL, 8'h86);
      for (k = 0; k < 300 && b_irq !== 1'b1; k++) step(1);
      check("b_irq", b_irq, 1'b1);
      rd(dmt_pkg::ADDR_INT_PEND);
      check("b_not_a", v[3], 1'b0);
      wr(dmt_pkg::ADDR_MAIN_CTL, 8'h01);
      step(2);
      check("b_off_wide", b_irq, 1'b0);
      summarize();
   end
endmodule : dual_mode_timer_sixteen_or_two_eight_bench
`default_nettype wire
